// ### hw/uart_adc_signal_routing.sv
// serial port and adc trigger routing option registers behind an axi4-lite slave
//
// Function
// - The serial transmit output is open drain when the open-drain enable bit 16 is 1, else a normal push-pull output.
// - The serial receiver takes the receive pin when bit 2 is 0 and the comparator output when it is 1.
// - Transmit bit 0 at 0 sends plain transmit data, at 1 sends it modulated by timer one channel 0.
// - With alternate-trigger bit 7 at 0 the adc hardware trigger comes from timer one channels 0 and 1.
// - In that mode a pre-trigger pulse on select line a precedes timer one channel 0, selecting config a and result a.
// - In that mode a pre-trigger pulse on select line b precedes timer one channel 1, selecting config b and result b.
// - With alternate triggering on, the hardware trigger is the event chosen by the trigger-source field.
// - The pre-trigger select bit 4 has no effect while alternate triggering is off.
// - Alternate triggering on with pre-trigger select 0 asserts select line a.
// - Reserved bits of both registers are read-only and read as zero.
// - Alternate triggering on with pre-trigger select 1 asserts select line b.
// - Trigger codes map 0 pin, 1 comparator, 8 and 9 timer overflows, c alarm, d seconds, e low-power timer; others give none.
`default_nettype none

module uart_adc_signal_routing (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic serial_tx_data,
    input wire logic serial_rx_pin,
    output logic serial_rx_data,
    output logic serial_tx_pin_out,
    output logic serial_tx_pin_oe_n,
    input wire logic analog_comparator_out,
    input wire logic timer_one_ch0,
    input wire logic timer_one_ch1,
    input wire logic external_trigger_input,
    input wire routing_pkg::trigger_events_s trigger_events,
    output logic adc_hardware_trigger,
    output logic adc_pretrigger_line_a,
    output logic adc_pretrigger_line_b
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic [1:0] reg_sel(input logic [15:0] addr);
        if (addr == routing_pkg::SERIAL_OPT_ADDR) begin
            return routing_pkg::SEL_SERIAL;
        end else if (addr == routing_pkg::ADC_OPT_ADDR) begin
            return routing_pkg::SEL_ADC;
        end
        return routing_pkg::SEL_NONE;
    endfunction : reg_sel

    function automatic logic [31:0] serial_word(input routing_pkg::routing_state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[routing_pkg::SER_ODE_BIT] = s.ode;
        w[routing_pkg::SER_RX_SRC_BIT] = s.rx_src;
        w[routing_pkg::SER_TX_SRC_BIT] = s.tx_src;
        return w;
    endfunction : serial_word

    function automatic logic [31:0] adc_word(input routing_pkg::routing_state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[routing_pkg::ADC_ALT_EN_BIT] = s.alt_en;
        w[routing_pkg::ADC_PRE_SEL_BIT] = s.pre_sel;
        w[routing_pkg::ADC_TRG_SEL_LSB +: routing_pkg::TRG_SEL_W] = s.trg_sel;
        return w;
    endfunction : adc_word

    // byte lanes without a strobe keep their old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return ((old & ~lanes) | (data & lanes)) & mask;
    endfunction : merge

    routing_pkg::routing_state_s state_ff;
    routing_pkg::routing_state_s nxt_state;
    logic tx_mod;
    logic sel_trig;
    logic [31:0] new_word;

    // ------------------------------------------------------------------
    // trigger source selection
    // ------------------------------------------------------------------
    always_comb begin
        case (state_ff.trg_sel)
            routing_pkg::TRG_EXT_PIN: sel_trig = state_ff.ext_filt;
            routing_pkg::TRG_COMPARATOR: sel_trig = analog_comparator_out;
            routing_pkg::TRG_TMR0_OVF: sel_trig = trigger_events.timer_zero_overflow;
            routing_pkg::TRG_TMR1_OVF: sel_trig = trigger_events.timer_one_overflow;
            routing_pkg::TRG_CLK_ALARM: sel_trig = trigger_events.clock_alarm;
            routing_pkg::TRG_CLK_SECONDS: sel_trig = trigger_events.clock_seconds;
            routing_pkg::TRG_LP_TIMER: sel_trig = trigger_events.low_power_timer;
            default: sel_trig = 1'b0;
        endcase
    end

    // modulation is a plain gate, so the carrier only appears on ones
    assign tx_mod = state_ff.tx_src ? (serial_tx_data & timer_one_ch0) : serial_tx_data;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        new_word = 32'h0000_0000;

        // write: address and data taken in either order, applied once both held
        if (state_ff.wr_state == routing_pkg::WR_IDLE) begin
            if (state_ff.aw_got && state_ff.w_got) begin
                nxt_state.aw_got = 1'b0;
                nxt_state.w_got = 1'b0;
                nxt_state.wr_state = routing_pkg::WR_RESP;
                nxt_state.bresp = routing_pkg::RESP_OKAY;
                case (reg_sel(state_ff.awaddr))
                    routing_pkg::SEL_SERIAL: begin
                        new_word = merge(serial_word(state_ff), state_ff.wdata,
                                         state_ff.wstrb, routing_pkg::SERIAL_OPT_MASK);
                        nxt_state.ode = new_word[routing_pkg::SER_ODE_BIT];
                        nxt_state.rx_src = new_word[routing_pkg::SER_RX_SRC_BIT];
                        nxt_state.tx_src = new_word[routing_pkg::SER_TX_SRC_BIT];
                    end
                    routing_pkg::SEL_ADC: begin
                        new_word = merge(adc_word(state_ff), state_ff.wdata,
                                         state_ff.wstrb, routing_pkg::ADC_OPT_MASK);
                        nxt_state.alt_en = new_word[routing_pkg::ADC_ALT_EN_BIT];
                        nxt_state.pre_sel = new_word[routing_pkg::ADC_PRE_SEL_BIT];
                        nxt_state.trg_sel =
                            new_word[routing_pkg::ADC_TRG_SEL_LSB +: routing_pkg::TRG_SEL_W];
                    end
                    default: nxt_state.bresp = routing_pkg::RESP_SLVERR;
                endcase
            end else begin
                if (awvalid && !state_ff.aw_got) begin
                    nxt_state.aw_got = 1'b1;
                    nxt_state.awaddr = awaddr;
                end
                if (wvalid && !state_ff.w_got) begin
                    nxt_state.w_got = 1'b1;
                    nxt_state.wdata = wdata;
                    nxt_state.wstrb = wstrb;
                end
            end
        end else if (bready) begin
            nxt_state.wr_state = routing_pkg::WR_IDLE;
        end

        // read
        case (state_ff.rd_state)
            routing_pkg::RD_IDLE: begin
                if (arvalid) begin
                    nxt_state.rd_state = routing_pkg::RD_DATA;
                    nxt_state.rresp = routing_pkg::RESP_OKAY;
                    case (reg_sel(araddr))
                        routing_pkg::SEL_SERIAL: nxt_state.rdata = serial_word(state_ff);
                        routing_pkg::SEL_ADC: nxt_state.rdata = adc_word(state_ff);
                        default: begin
                            nxt_state.rdata = 32'h0000_0000;
                            nxt_state.rresp = routing_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            routing_pkg::RD_DATA: begin
                if (rready) begin
                    nxt_state.rd_state = routing_pkg::RD_IDLE;
                end
            end
            default: nxt_state.rd_state = routing_pkg::RD_IDLE;
        endcase

        // pin synchronisers: a change counts once stages two and three agree
        nxt_state.rx_sync = {state_ff.rx_sync[1:0], serial_rx_pin};
        if (state_ff.rx_sync[2] == state_ff.rx_sync[1]) begin
            nxt_state.rx_filt = state_ff.rx_sync[2];
        end
        nxt_state.ext_sync = {state_ff.ext_sync[1:0], external_trigger_input};
        if (state_ff.ext_sync[2] == state_ff.ext_sync[1]) begin
            nxt_state.ext_filt = state_ff.ext_sync[2];
        end

        // serial routing
        nxt_state.rx_data = state_ff.rx_src ? analog_comparator_out : state_ff.rx_filt;
        if (state_ff.ode) begin
            nxt_state.tx_out = 1'b0;
            nxt_state.tx_oe_n = tx_mod;
        end else begin
            nxt_state.tx_out = tx_mod;
            nxt_state.tx_oe_n = 1'b0;
        end

        // adc triggering; channel edge gives the pre-trigger one cycle ahead
        nxt_state.ch0_d = timer_one_ch0;
        nxt_state.ch1_d = timer_one_ch1;
        if (state_ff.alt_en) begin
            nxt_state.hw_trig = sel_trig;
            nxt_state.pre_a = !state_ff.pre_sel;
            nxt_state.pre_b = state_ff.pre_sel;
        end else begin
            nxt_state.pre_a = timer_one_ch0 && !state_ff.ch0_d;
            nxt_state.pre_b = timer_one_ch1 && !state_ff.ch1_d;
            nxt_state.hw_trig = state_ff.ch0_d || state_ff.ch1_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= routing_pkg::STATE_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign awready = (state_ff.wr_state == routing_pkg::WR_IDLE) && !state_ff.aw_got;
    assign wready = (state_ff.wr_state == routing_pkg::WR_IDLE) && !state_ff.w_got;
    assign bvalid = (state_ff.wr_state == routing_pkg::WR_RESP);
    assign bresp = state_ff.bresp;
    assign arready = (state_ff.rd_state == routing_pkg::RD_IDLE);
    assign rvalid = (state_ff.rd_state == routing_pkg::RD_DATA);
    assign rdata = state_ff.rdata;
    assign rresp = state_ff.rresp;
    assign serial_rx_data = state_ff.rx_data;
    assign serial_tx_pin_out = state_ff.tx_out;
    assign serial_tx_pin_oe_n = state_ff.tx_oe_n;
    assign adc_hardware_trigger = state_ff.hw_trig;
    assign adc_pretrigger_line_a = state_ff.pre_a;
    assign adc_pretrigger_line_b = state_ff.pre_b;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic pin_level;
    assign pin_level = serial_tx_pin_out | serial_tx_pin_oe_n;

    sequence s_ch0_rise;
        (!state_ff.alt_en && timer_one_ch0 && !state_ff.ch0_d) ##1 !state_ff.alt_en;
    endsequence

    sequence s_ch1_rise;
        (!state_ff.alt_en && timer_one_ch1 && !state_ff.ch1_d) ##1 !state_ff.alt_en;
    endsequence

    chk_open_drain_drive: assert property (
        state_ff.ode |=> !serial_tx_pin_out && serial_tx_pin_oe_n == $past(tx_mod))
        else $error("open drain output drives high");
    chk_push_pull_drive: assert property (
        !state_ff.ode |=> !serial_tx_pin_oe_n && serial_tx_pin_out == $past(tx_mod))
        else $error("push pull output released");
    chk_rx_source: assert property (
        state_ff.rx_src |=> serial_rx_data == $past(analog_comparator_out))
        else $error("receiver not fed from comparator");
    chk_tx_modulated: assert property (
        state_ff.tx_src |=> pin_level == $past(serial_tx_data & timer_one_ch0))
        else $error("transmit not modulated");
    chk_tx_plain: assert property (
        !state_ff.tx_src |=> pin_level == $past(serial_tx_data))
        else $error("transmit data altered");
    chk_pre_a_first: assert property (
        s_ch0_rise |-> adc_pretrigger_line_a ##1 adc_hardware_trigger)
        else $error("pre-trigger a not ahead of trigger");
    chk_pre_b_first: assert property (
        s_ch1_rise |-> adc_pretrigger_line_b ##1 adc_hardware_trigger)
        else $error("pre-trigger b not ahead of trigger");
    chk_alt_source: assert property (
        state_ff.alt_en |=> adc_hardware_trigger == $past(sel_trig))
        else $error("alternate trigger not followed");
    chk_pre_sel_ignored: assert property (
        !state_ff.alt_en && !(timer_one_ch0 && !state_ff.ch0_d) |=> !adc_pretrigger_line_a)
        else $error("pre-trigger select acted while alternate off");
    chk_alt_line_a: assert property (
        state_ff.alt_en && !state_ff.pre_sel |=> adc_pretrigger_line_a && !adc_pretrigger_line_b)
        else $error("select line a not asserted");
    chk_reserved_zero: assert property (
        rvalid |-> (rdata & ~(routing_pkg::SERIAL_OPT_MASK | routing_pkg::ADC_OPT_MASK)) == 0)
        else $error("reserved bits read nonzero");
    chk_alt_line_b: assert property (
        state_ff.alt_en && state_ff.pre_sel |=> adc_pretrigger_line_b && !adc_pretrigger_line_a)
        else $error("select line b not asserted");
    chk_lp_timer_code: assert property (
        state_ff.alt_en && state_ff.trg_sel == routing_pkg::TRG_LP_TIMER
        |=> adc_hardware_trigger == $past(trigger_events.low_power_timer))
        else $error("low-power timer code misrouted");
    chk_reset_values: assert property (
        $rose(aresetn) |-> !state_ff.ode && !state_ff.rx_src && !state_ff.tx_src
                           && !state_ff.alt_en && !state_ff.pre_sel && state_ff.trg_sel == 0)
        else $error("routing bits not cleared by reset");
    chk_bvalid_holds: assert property (
        bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    chk_line_b_quiet: assert property (
        !state_ff.alt_en && state_ff.pre_sel && !(timer_one_ch1 && !state_ff.ch1_d)
        |=> !adc_pretrigger_line_b)
        else $error("pre-trigger select drove line b while alternate off");
    chk_write_answer: assert property (
        state_ff.aw_got && state_ff.w_got |=> bvalid)
        else $error("write response late");
    chk_read_answer: assert property (
        arvalid && arready |=> rvalid)
        else $error("read data late");

endmodule : uart_adc_signal_routing

`default_nettype wire

// ### hw/routing_pkg.sv
// routing option register map, field layout, trigger codes and block state type
`default_nettype none

package routing_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [15:0] SERIAL_OPT_ADDR = 16'h1010;
    localparam logic [15:0] ADC_OPT_ADDR = 16'h1018;

    // ------------------------------------------------------------------
    // field positions and writable masks
    // ------------------------------------------------------------------
    localparam int SER_ODE_BIT = 16;
    localparam int SER_RX_SRC_BIT = 2;
    localparam int SER_TX_SRC_BIT = 0;
    localparam int ADC_ALT_EN_BIT = 7;
    localparam int ADC_PRE_SEL_BIT = 4;
    localparam int ADC_TRG_SEL_LSB = 0;
    localparam int TRG_SEL_W = 4;
    localparam logic [31:0] SERIAL_OPT_MASK = 32'h0001_0005;
    localparam logic [31:0] ADC_OPT_MASK = 32'h0000_009f;

    // ------------------------------------------------------------------
    // trigger source codes
    // ------------------------------------------------------------------
    localparam logic [3:0] TRG_EXT_PIN = 4'h0;
    localparam logic [3:0] TRG_COMPARATOR = 4'h1;
    localparam logic [3:0] TRG_TMR0_OVF = 4'h8;
    localparam logic [3:0] TRG_TMR1_OVF = 4'h9;
    localparam logic [3:0] TRG_CLK_ALARM = 4'hc;
    localparam logic [3:0] TRG_CLK_SECONDS = 4'hd;
    localparam logic [3:0] TRG_LP_TIMER = 4'he;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h0;
    localparam logic [1:0] SEL_SERIAL = 2'h1;
    localparam logic [1:0] SEL_ADC = 2'h2;

    typedef enum logic {WR_IDLE, WR_RESP} wr_state_e;
    typedef enum logic {RD_IDLE, RD_DATA} rd_state_e;

    // on-chip peripheral events, all on the bus clock
    typedef struct packed {
        logic timer_zero_overflow;
        logic timer_one_overflow;
        logic clock_alarm;
        logic clock_seconds;
        logic low_power_timer;
    } trigger_events_s;

    typedef struct packed {
        wr_state_e wr_state;
        logic aw_got;
        logic w_got;
        logic [15:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        rd_state_e rd_state;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ode;
        logic rx_src;
        logic tx_src;
        logic alt_en;
        logic pre_sel;
        logic [3:0] trg_sel;
        logic [2:0] rx_sync;
        logic rx_filt;
        logic [2:0] ext_sync;
        logic ext_filt;
        logic ch0_d;
        logic ch1_d;
        logic tx_out;
        logic tx_oe_n;
        logic rx_data;
        logic hw_trig;
        logic pre_a;
        logic pre_b;
    } routing_state_s;

    localparam routing_state_s STATE_RESET = '{
        wr_state: WR_IDLE, aw_got: 1'b0, w_got: 1'b0, awaddr: 16'h0000,
        wdata: 32'h0000_0000, wstrb: 4'h0, bresp: 2'h0,
        rd_state: RD_IDLE, rdata: 32'h0000_0000, rresp: 2'h0,
        ode: 1'b0, rx_src: 1'b0, tx_src: 1'b0, alt_en: 1'b0, pre_sel: 1'b0,
        trg_sel: 4'h0, rx_sync: 3'h7, rx_filt: 1'b1, ext_sync: 3'h0,
        ext_filt: 1'b0, ch0_d: 1'b0, ch1_d: 1'b0, tx_out: 1'b1,
        tx_oe_n: 1'b0, rx_data: 1'b1, hw_trig: 1'b0, pre_a: 1'b0,
        pre_b: 1'b0
    };

endpackage : routing_pkg

`default_nettype wire

// ### verification/timer_one_model.sv
// behavioural timer one model driving both channel outputs into the routing block
`default_nettype none

module timer_one_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] fire,
    input wire logic [1:0] hold,
    output logic ch0,
    output logic ch1
);
    timeunit 1ns;
    timeprecision 1ps;

    // fire gives a one-cycle compare match; hold keeps a channel high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ch0 <= 1'b0;
            ch1 <= 1'b0;
        end else begin
            ch0 <= fire[0] | hold[0];
            ch1 <= fire[1] | hold[1];
        end
    end
endmodule : timer_one_model

`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the serial and adc routing option registers
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } row_s;

    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [15:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, rr, fire, hold, pre_lines;
    logic serial_tx_data, serial_rx_pin, serial_rx_data, serial_tx_pin_out, serial_tx_pin_oe_n;
    logic analog_comparator_out, timer_one_ch0, timer_one_ch1, external_trigger_input;
    logic adc_hardware_trigger, adc_pretrigger_line_a, adc_pretrigger_line_b;
    routing_pkg::trigger_events_s trigger_events;
    int fails, total_checks;
    row_s rows [6] = '{
        '{16'h1010, 32'hffff_ffff, 32'h0001_0005, 2'h0},
        '{16'h1018, 32'hffff_ffff, 32'h0000_009f, 2'h0},
        '{16'h1010, 32'hfffe_fffa, 32'h0000_0000, 2'h0},
        '{16'h1018, 32'hffff_ff60, 32'h0000_0000, 2'h0},
        '{16'h1014, 32'h0000_0001, 32'h0000_0000, 2'h2},
        '{16'h1000, 32'hffff_ffff, 32'h0000_0000, 2'h2}
    };

    assign pre_lines = {adc_pretrigger_line_b, adc_pretrigger_line_a};

    uart_adc_signal_routing uart_adc_signal_routing_inst (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .serial_tx_data, .serial_rx_pin, .serial_rx_data, .serial_tx_pin_out,
        .serial_tx_pin_oe_n, .analog_comparator_out, .timer_one_ch0, .timer_one_ch1,
        .external_trigger_input, .trigger_events, .adc_hardware_trigger,
        .adc_pretrigger_line_a, .adc_pretrigger_line_b
    );

    timer_one_model timer_one_model_inst (
        .aclk, .aresetn, .fire, .hold, .ch0(timer_one_ch0), .ch1(timer_one_ch1)
    );

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // address and data are offered together; each is released once taken
    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] rsp);
        bit aw_d = 0;
        bit w_d = 0;
        bit b_d = 0;
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_d && n < 100) begin
            @(posedge aclk);
            n++;
            if (!aw_d && awready) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_d && wready) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                b_d = 1'b1;
                rsp = bresp;
                bready <= 1'b0;
            end
        end
        if (!b_d) begin
            fails++;
            summarize();
        end
    endtask : axi_write

    task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] rsp);
        bit ar_d = 0;
        bit r_d = 0;
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_d && n < 100) begin
            @(posedge aclk);
            n++;
            if (!ar_d && arready) begin
                ar_d = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                r_d = 1'b1;
                d = rdata;
                rsp = rresp;
                rready <= 1'b0;
            end
        end
        if (!r_d) begin
            fails++;
            summarize();
        end
    endtask : axi_read

    function automatic int src_of(input logic [3:0] c);
        case (c)
            4'h0: return 0;
            4'h1: return 1;
            4'h8: return 2;
            4'h9: return 3;
            4'hc: return 4;
            4'hd: return 5;
            4'he: return 6;
            default: return 7;
        endcase
    endfunction : src_of

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, fire, hold} = '0;
        {awaddr, araddr, wdata, external_trigger_input, analog_comparator_out} = '0;
        {serial_tx_data, serial_rx_pin, wstrb} = 6'h3f;
        trigger_events = '0;
        fails = 0;
        total_checks = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            axi_write(rows[i].a, rows[i].d, r);
            check("bresp", r, rows[i].r);
            axi_read(rows[i].a, rd, rr);
            check("rdata", rd, rows[i].e);
            check("rresp", rr, rows[i].r);
        end
        // upper lanes unstrobed: bit 16 must keep its cleared value
        wstrb <= 4'h3;
        axi_write(16'h1010, 32'hffff_ffff, r);
        wstrb <= 4'hf;
        axi_read(16'h1010, rd, rr);
        check("strb_keep", rd, 32'h0000_0005);
        $display("test register rows done");
        for (int s = 0; s < 2; s++) begin
            axi_write(16'h1010, 32'(s), r);
            for (int i = 0; i < 4; i++) begin
                serial_tx_data <= i[1];
                hold <= {1'b0, i[0]};
                repeat (4) @(posedge aclk);
                check("tx_out", serial_tx_pin_out, i[1] & (i[0] | !s));
                check("tx_oe_n", serial_tx_pin_oe_n, 0);
            end
        end
        axi_write(16'h1010, 32'h0001_0000, r);
        for (int i = 0; i < 2; i++) begin
            serial_tx_data <= i[0];
            repeat (4) @(posedge aclk);
            check("od_out", serial_tx_pin_out, 0);
            check("od_oe_n", serial_tx_pin_oe_n, i[0]);
        end
        for (int s = 0; s < 2; s++) begin
            axi_write(16'h1010, {29'h0, s[0], 2'h0}, r);
            for (int i = 0; i < 2; i++) begin
                serial_rx_pin <= i[0];
                analog_comparator_out <= !i[0];
                repeat (8) @(posedge aclk);
                check("rx_data", serial_rx_data, s[0] ^ i[0]);
            end
        end
        $display("test serial routing done");
        // pre-select set on purpose: timer mode must ignore it
        axi_write(16'h1018, 32'h0000_0010, r);
        hold <= 2'b00;
        // let channel 0 fall first so the fire below is a real rise
        repeat (4) @(posedge aclk);
        for (int c = 0; c < 2; c++) begin
            bit seen;
            int n;
            seen = 0;
            n = 0;
            fire[c] <= 1'b1;
            @(posedge aclk);
            fire <= 2'b00;
            while (!seen && n < 8) begin
                @(posedge aclk);
                n++;
                seen = pre_lines[c];
            end
            check("pre_seen", seen, 1);
            check("pre_other", pre_lines[1-c], 0);
            check("trig_early", adc_hardware_trigger, 0);
            @(posedge aclk);
            check("trig", adc_hardware_trigger, 1);
            check("pre_len", pre_lines[c], 0);
        end
        $display("test timer triggering done");
        hold <= 2'b11;
        for (int code = 0; code < 16; code++) begin
            axi_write(16'h1018, {24'h0, 1'b1, 2'b0, code[0], code[3:0]}, r);
            for (int s = 0; s < 7; s++) begin
                external_trigger_input <= (s == 0);
                analog_comparator_out <= (s == 1);
                trigger_events <= routing_pkg::trigger_events_s'({s == 2, s == 3, s == 4,
                    s == 5, s == 6});
                repeat (8) @(posedge aclk);
                check("alt_trig", adc_hardware_trigger, src_of(code[3:0]) == s);
                check("alt_pre", pre_lines, code[0] ? 2'b10 : 2'b01);
            end
        end
        $display("test alternate triggering done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(16'h1010, rd, rr);
        check("serial_reset", rd, 0);
        axi_read(16'h1018, rd, rr);
        check("adc_reset", rd, 0);
        repeat (4) @(posedge aclk);
        check("tx_reset", serial_tx_pin_out, serial_tx_data);
        check("oe_reset", serial_tx_pin_oe_n, 0);
        check("trig_reset", adc_hardware_trigger, 1);
        $display("test second reset done");
        summarize();
    end
endmodule : testbench

`default_nettype wire
